//--- src/lis_device.sv
/*
 * Device end: lock event interrupts, live status,
 * divide-by-4 alignment and a free data clock.
 * Assumes all inputs are synchronous to I_MCLK,
 * the converter update clock.
 */
// What this block does
// [R1] One active-high request output for lock changes.
// [R2] Delay, receiver, sync each latch lock/lost events.
// [R3] Enable register mirrors status register bit positions.
// [R4] Bits: sync lost/locked, delay, receiver, high-low.
// [R5] Event latched only on false-to-true transition.
// [R6] Host checks live status before restoring lock.
// [R7] Writing enable 0 then 1 clears event.
// [R8] Host enables lock events stepwise, lost ones last.
// [R9] Live status readable in two registers.
// [R10] Data-path divide-by-4 starts in unknown phase.
// [R11] Master outputs quarter-rate reference to all.
// [R12] Slave rotates divider until reference between 0/90.
// [R13] Manual rotation refused while sync enabled.
// [R14] Data clock from separate randomly phased divider; here it always starts at LIS_DCO_START.
// [R15] Aligned devices run data divider in same phase.
// [R16] Host programs identical settings, checks delays back.
// [R17] Host writes 0x70 master, 0x50 slave.
// [R18] Request high while any enabled event latched.
`timescale 1ns/100ps
module lis_device
   import lis_pkg::*;
#(
   parameter logic [1:0] DP_START = 2'h0
) (
   input  wire logic       I_MCLK,
   input  wire logic       I_ARST_N,
   input  wire logic       I_DELAY_LOCKED_NOW,
   input  wire logic       I_DELAY_LOST_NOW,
   input  wire logic       I_RECEIVER_LOCKED_NOW,
   input  wire logic       I_RECEIVER_LOST_NOW,
   input  wire logic       I_RECEIVER_TRACKING_ACTIVE,
   input  wire logic       I_SYNC_IN,
   output logic            O_SYNC_OUT,
   output logic            O_DATA_CLOCK_OUTPUT,
   output logic [1:0]      O_DP_PHASE,
   lis_if.device           bus
);

   typedef struct packed {
      logic [LIS_NEV-1:0] en;
      logic [LIS_NEV-1:0] status;
      logic [LIS_NEV-1:0] prev;
      logic               irq;
      logic [7:0]         sync_ctrl;
      logic               rot_pend;
      logic [1:0]         dp_cnt;
      logic [1:0]         dco_cnt;
      logic               data_clock_output;
      logic               sync_out;
      logic               ph0;
      logic               ph90;
      logic [2:0]         good_cnt;
      logic               sync_locked;
      logic               sync_lost;
      logic               ack;
      logic [LIS_DW-1:0]  rdata;
   } lis_dev_st_t;

   lis_dev_st_t        st_ff;
   lis_dev_st_t        nxt_st;
   logic [LIS_NEV-1:0] cond;
   logic [LIS_NEV-1:0] rise;
   logic               sync_en;
   logic               master;
   logic [1:0]         step;

   function automatic logic [LIS_DW-1:0] dev_read(input logic [LIS_AW-1:0] a,
      input lis_dev_st_t s);
      logic [LIS_DW-1:0] d;
      d = 8'h00;
      unique case (a)
         LIS_ADDR_IRQ_EN:  d = {2'h0, s.en};
         LIS_ADDR_IRQ_ST:  d = {2'h0, s.status};
         LIS_ADDR_PH_ST:   d = {2'h0, s.ph90, s.ph0, 4'h0};
         LIS_ADDR_SYNC:    d = s.sync_ctrl;
         // [R9] Receiver and sync live status.
         LIS_ADDR_RS_LIVE: d = {s.sync_ctrl[LIS_SC_EN_BIT] & s.sync_locked, 1'b0,
                                s.sync_lost, s.sync_locked, I_RECEIVER_TRACKING_ACTIVE,
                                1'b0, I_RECEIVER_LOST_NOW, I_RECEIVER_LOCKED_NOW};
         // [R9] Delay controller live status.
         LIS_ADDR_DL_LIVE: d = {6'h00, I_DELAY_LOST_NOW, I_DELAY_LOCKED_NOW};
         default:          d = 8'h00;
      endcase
      return d;
   endfunction

   // [R2] Three sources, lock and lost each.
   // [R4] Event order sync, delay, receiver.
   assign cond = {st_ff.sync_lost, st_ff.sync_locked, I_DELAY_LOST_NOW,
                  I_DELAY_LOCKED_NOW, I_RECEIVER_LOST_NOW, I_RECEIVER_LOCKED_NOW};
   // [R5] Rising transition detect only.
   assign rise    = cond & ~st_ff.prev;
   assign sync_en = st_ff.sync_ctrl[LIS_SC_EN_BIT];
   assign master  = st_ff.sync_ctrl[LIS_SC_MST_BIT];

   always_comb begin
      nxt_st = st_ff;
      step   = 2'h1;

      nxt_st.ack = 1'b0;
      if (bus.req && !st_ff.ack) begin
         nxt_st.ack   = 1'b1;
         nxt_st.rdata = dev_read(bus.addr, st_ff);
         if (bus.we) begin
            unique case (bus.addr)
               // [R3] Enable uses the status layout.
               LIS_ADDR_IRQ_EN: nxt_st.en = bus.wdata[LIS_NEV-1:0];
               LIS_ADDR_SYNC:   nxt_st.sync_ctrl = bus.wdata;
               LIS_ADDR_ROTATE: begin
                  // [R13] Manual rotate refused when enabled.
                  if (!sync_en && bus.wdata[0]) begin
                     nxt_st.rot_pend = 1'b1;
                  end
               end
               default: ;
            endcase
         end
      end

      // Manual rotation skips one divider state.
      if (st_ff.rot_pend) begin
         step            = 2'h2;
         nxt_st.rot_pend = 1'b0;
      end

      // [R12] Sample reference at 0 and 90 degrees.
      if (st_ff.dp_cnt == LIS_PH0) begin
         nxt_st.ph0 = I_SYNC_IN;
      end
      if (st_ff.dp_cnt == LIS_PH90) begin
         nxt_st.ph90 = I_SYNC_IN;
      end
      if (sync_en && st_ff.dp_cnt == LIS_PH_CHECK) begin
         if (!st_ff.ph0 && st_ff.ph90) begin
            if (st_ff.good_cnt == LIS_LOCK_LAST) begin
               nxt_st.sync_locked = 1'b1;
               nxt_st.sync_lost   = 1'b0;
            end else begin
               nxt_st.good_cnt = st_ff.good_cnt + 3'h1;
            end
         end else begin
            nxt_st.good_cnt = 3'h0;
            if (st_ff.sync_locked) begin
               nxt_st.sync_locked = 1'b0;
               nxt_st.sync_lost   = 1'b1;
            end
            // [R12] Slave rotates its divider one step.
            if (!master) begin
               step = 2'h2;
            end
         end
      end
      if (!sync_en) begin
         nxt_st.good_cnt    = 3'h0;
         nxt_st.sync_locked = 1'b0;
         nxt_st.sync_lost   = 1'b0;
      end

      // [R15] Data-path divider, aligned once locked.
      nxt_st.dp_cnt = st_ff.dp_cnt + step;
      // [R11] Master reference high in phases 90 and 180.
      nxt_st.sync_out = sync_en && master &&
                        (nxt_st.dp_cnt == LIS_PH90 || nxt_st.dp_cnt == LIS_PH_CHECK);
      // [R14] Separate free-running data clock divider.
      nxt_st.dco_cnt = st_ff.dco_cnt + 2'h1;
      nxt_st.data_clock_output     = nxt_st.dco_cnt[1];

      nxt_st.prev = cond;
      // [R7] Disabling clears, a new event still wins.
      nxt_st.status = (st_ff.status & nxt_st.en) | (rise & st_ff.en);
      // [R18] Request while an enabled event is latched.
      nxt_st.irq = |(nxt_st.status & nxt_st.en);
   end

   // [R10] Divider start phase is arbitrary until aligned.
   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         st_ff           <= '0;
         st_ff.sync_ctrl <= LIS_SC_RESET;
         st_ff.dp_cnt    <= DP_START;
         st_ff.dco_cnt   <= LIS_DCO_START;
         st_ff.data_clock_output       <= LIS_DCO_START[1];
      end else begin
         st_ff <= nxt_st;
      end
   end

   // [R1] Single active-high request output.
   assign bus.irq             = st_ff.irq;
   assign bus.ack             = st_ff.ack;
   assign bus.rdata           = st_ff.rdata;
   assign O_SYNC_OUT          = st_ff.sync_out;
   assign O_DATA_CLOCK_OUTPUT = st_ff.data_clock_output;
   assign O_DP_PHASE          = st_ff.dp_cnt;

endmodule // lis_device

//--- src/lis_host.sv
/*
 * Controller end: AXI4-Lite registers that drive the device register port.
 * Assumes every device request is answered by a one-cycle ack.
 */
`timescale 1ns/100ps
module lis_host
   import lis_pkg::*;
(
   input  wire logic                  I_MCLK,
   input  wire logic                  I_ARST_N,
   input  wire logic                  I_AWVALID,
   output logic                       O_AWREADY,
   input  wire logic [LIS_AXI_AW-1:0] I_AWADDR,
   input  wire logic                  I_WVALID,
   output logic                       O_WREADY,
   input  wire logic [31:0]           I_WDATA,
   input  wire logic [3:0]            I_WSTRB,
   output logic                       O_BVALID,
   input  wire logic                  I_BREADY,
   output logic [1:0]                 O_BRESP,
   input  wire logic                  I_ARVALID,
   output logic                       O_ARREADY,
   input  wire logic [LIS_AXI_AW-1:0] I_ARADDR,
   output logic                       O_RVALID,
   input  wire logic                  I_RREADY,
   output logic [31:0]                O_RDATA,
   output logic [1:0]                 O_RRESP,
   output logic                       O_IRQ,
   lis_if.host                        bus
);

   typedef enum logic [1:0] {JOB_CMD, JOB_CLR, JOB_SYNC, JOB_SNAP} lis_job_t;
   typedef enum logic [1:0] {H_IDLE, H_REQ, H_NEXT} lis_hstate_t;

   typedef struct packed {
      logic awrdy; logic wrdy; logic bvalid; logic arrdy; logic rvalid;
      logic [LIS_AXI_AW-1:0] awaddr;
      logic [31:0] wdata;
      logic [31:0] rdata;
      lis_hstate_t hs;
      lis_job_t job;
      logic [1:0] stp; logic [16:0] cmd; logic [5:0] clr_mask; logic sync_master;
      logic [5:0] en_shadow; logic [7:0] last_rd; logic [23:0] snap; logic snap_pend;
      logic irq_prev; logic [2:0] ist; logic [2:0] imask; logic irq;
      logic req; logic we; logic [7:0] addr; logic [7:0] wd;
   } lis_host_st_t;

   lis_host_st_t st_ff;
   lis_host_st_t nxt_st;
   logic [2:0]   hev;
   logic [16:0]  op;

   // {we, addr, data} of a job's current step.
   function automatic logic [16:0] job_op(input lis_host_st_t s);
      logic [16:0] o;
      o = 17'h0;
      unique case (s.job)
         JOB_CMD:  o = s.cmd;
         // [R7] Write enable 0, then 1 again.
         JOB_CLR:  o = {1'b1, LIS_ADDR_IRQ_EN, 2'h0,
                        (s.stp == 2'h0) ? (s.en_shadow & ~s.clr_mask)
                                        : (s.en_shadow | s.clr_mask)};
         // [R17] Master and slave sync enable values.
         JOB_SYNC: o = {1'b1, LIS_ADDR_SYNC, s.sync_master ? LIS_SC_MASTER : LIS_SC_SLAVE};
         // [R6] Read events, then both live registers.
         JOB_SNAP: o = {1'b0, (s.stp == 2'h0) ? LIS_ADDR_IRQ_ST :
                              (s.stp == 2'h1) ? LIS_ADDR_RS_LIVE : LIS_ADDR_DL_LIVE, 8'h00};
      endcase
      return o;
   endfunction

   function automatic logic [1:0] job_last(input lis_job_t j);
      return (j == JOB_CLR) ? 2'h1 : (j == JOB_SNAP) ? 2'h2 : 2'h0;
   endfunction

   assign op = job_op(st_ff);

   always_comb begin
      nxt_st = st_ff;
      hev    = 3'h0;

      // AXI4-Lite write: address and data in either order.
      if (st_ff.awrdy && I_AWVALID) begin
         nxt_st.awrdy  = 1'b0;
         nxt_st.awaddr = I_AWADDR;
      end
      if (st_ff.wrdy && I_WVALID) begin
         nxt_st.wrdy  = 1'b0;
         nxt_st.wdata = I_WDATA;
      end
      if (!st_ff.awrdy && !st_ff.wrdy && !st_ff.bvalid) begin
         nxt_st.bvalid = 1'b1;
         unique case (st_ff.awaddr)
            LIS_H_CMD: if (st_ff.hs == H_IDLE) begin
               nxt_st.cmd = {st_ff.wdata[LIS_CMD_WE_BIT], st_ff.wdata[15:0]};
               nxt_st.job = JOB_CMD;
               nxt_st.hs  = H_NEXT;
            end
            LIS_H_ACK: if (st_ff.hs == H_IDLE) begin
               nxt_st.clr_mask = st_ff.wdata[5:0];
               nxt_st.job      = JOB_CLR;
               nxt_st.hs       = H_NEXT;
            end
            LIS_H_SYNC: if (st_ff.hs == H_IDLE) begin
               nxt_st.sync_master = st_ff.wdata[0];
               nxt_st.job         = JOB_SYNC;
               nxt_st.hs          = H_NEXT;
            end
            LIS_H_IRQ_MASK: nxt_st.imask = st_ff.wdata[2:0];
            default: ;
         endcase
      end
      if (st_ff.bvalid && I_BREADY) begin
         nxt_st.bvalid = 1'b0;
         nxt_st.awrdy  = 1'b1;
         nxt_st.wrdy   = 1'b1;
      end

      // A device request edge queues a snapshot.
      nxt_st.irq_prev = bus.irq;
      if (bus.irq && !st_ff.irq_prev) begin
         hev[LIS_HI_DEV_IRQ] = 1'b1;
         nxt_st.snap_pend    = 1'b1;
      end
      if (nxt_st.hs == H_IDLE && nxt_st.snap_pend) begin
         nxt_st.snap_pend = 1'b0;
         nxt_st.job       = JOB_SNAP;
         nxt_st.hs        = H_NEXT;
      end

      unique case (st_ff.hs)
         H_IDLE: nxt_st.stp = 2'h0;
         H_NEXT: begin
            nxt_st.req  = 1'b1;
            nxt_st.we   = op[16];
            nxt_st.addr = op[15:8];
            nxt_st.wd   = op[7:0];
            nxt_st.hs   = H_REQ;
            if (op[16] && op[15:8] == LIS_ADDR_IRQ_EN) begin
               nxt_st.en_shadow = op[5:0];
            end
         end
         H_REQ: if (bus.ack) begin
            nxt_st.req     = 1'b0;
            nxt_st.last_rd = bus.rdata;
            if (st_ff.job == JOB_SNAP) begin
               nxt_st.snap = {st_ff.snap[15:0], bus.rdata};
            end
            if (st_ff.stp == job_last(st_ff.job)) begin
               nxt_st.hs = H_IDLE;
               if (st_ff.job == JOB_SNAP) begin
                  hev[LIS_HI_SNAP_DONE] = 1'b1;
               end else begin
                  hev[LIS_HI_CMD_DONE] = 1'b1;
               end
            end else begin
               nxt_st.stp = st_ff.stp + 2'h1;
               nxt_st.hs  = H_NEXT;
            end
         end
         default: ;
      endcase

      // AXI4-Lite read; status clears on read, new events win.
      if (st_ff.rvalid && I_RREADY) begin
         nxt_st.rvalid = 1'b0;
         nxt_st.arrdy  = 1'b1;
      end
      nxt_st.ist = st_ff.ist;
      if (st_ff.arrdy && I_ARVALID) begin
         nxt_st.arrdy  = 1'b0;
         nxt_st.rvalid = 1'b1;
         unique case (I_ARADDR)
            LIS_H_CMD:      nxt_st.rdata = {15'h0, st_ff.cmd};
            LIS_H_RESULT:   nxt_st.rdata = {st_ff.hs != H_IDLE, 23'h0, st_ff.last_rd};
            LIS_H_SNAP:     nxt_st.rdata = {8'h00, st_ff.snap};
            LIS_H_IRQ_ST: begin
               nxt_st.rdata = {29'h0, st_ff.ist};
               nxt_st.ist   = 3'h0;
            end
            LIS_H_IRQ_MASK: nxt_st.rdata = {29'h0, st_ff.imask};
            default:        nxt_st.rdata = 32'h0;
         endcase
      end
      nxt_st.ist = nxt_st.ist | hev;
      nxt_st.irq = |(nxt_st.ist & nxt_st.imask);
   end

   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         st_ff       <= '0;
         st_ff.awrdy <= 1'b1;
         st_ff.wrdy  <= 1'b1;
         st_ff.arrdy <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign O_AWREADY = st_ff.awrdy;
   assign O_WREADY  = st_ff.wrdy;
   assign O_BVALID  = st_ff.bvalid;
   assign O_BRESP   = LIS_RESP_OKAY;
   assign O_ARREADY = st_ff.arrdy;
   assign O_RVALID  = st_ff.rvalid;
   assign O_RDATA   = st_ff.rdata;
   assign O_RRESP   = LIS_RESP_OKAY;
   assign O_IRQ     = st_ff.irq;
   assign bus.req   = st_ff.req;
   assign bus.we    = st_ff.we;
   assign bus.addr  = st_ff.addr;
   assign bus.wdata = st_ff.wd;

endmodule // lis_host

//--- src/lis_if.sv
/*
 * Link between the device register port and the controller.
 * Assumes both ends run on the same clock; request held until acknowledged.
 */
`timescale 1ns/100ps
interface lis_if;
   import lis_pkg::*;
   logic              req;
   logic              we;
   logic [LIS_AW-1:0] addr;
   logic [LIS_DW-1:0] wdata;
   logic [LIS_DW-1:0] rdata;
   logic              ack;
   logic              irq;

   modport device (
      input  req,
      input  we,
      input  addr,
      input  wdata,
      output rdata,
      output ack,
      output irq
   );
   modport host (
      output req,
      output we,
      output addr,
      output wdata,
      input  rdata,
      input  ack,
      input  irq
   );
endinterface

//--- src/lis_pkg.sv
/*
 * Register maps, field positions and counts of the lock and sync block.
 * Assumes users import the whole package.
 */
package lis_pkg;
   // Device register port.
   localparam int unsigned LIS_AW           = 8;
   localparam int unsigned LIS_DW           = 8;
   localparam int unsigned LIS_NEV          = 6;
   localparam logic [7:0]  LIS_ADDR_IRQ_EN  = 8'h03;
   localparam logic [7:0]  LIS_ADDR_IRQ_ST  = 8'h04;
   localparam logic [7:0]  LIS_ADDR_PH_ST   = 8'h0D;
   localparam logic [7:0]  LIS_ADDR_SYNC    = 8'h10;
   localparam logic [7:0]  LIS_ADDR_ROTATE  = 8'h11;
   localparam logic [7:0]  LIS_ADDR_RS_LIVE = 8'h21;
   localparam logic [7:0]  LIS_ADDR_DL_LIVE = 8'h2A;
   // Event bits of the enable and status registers.
   localparam int unsigned LIS_EV_RCV_LCK   = 0;
   localparam int unsigned LIS_EV_RCV_LST   = 1;
   localparam int unsigned LIS_EV_DL_LCK    = 2;
   localparam int unsigned LIS_EV_DL_LST    = 3;
   localparam int unsigned LIS_EV_SYN_LCK   = 4;
   localparam int unsigned LIS_EV_SYN_LST   = 5;
   // Sync control fields and values.
   localparam int unsigned LIS_SC_EN_BIT    = 6;
   localparam int unsigned LIS_SC_MST_BIT   = 5;
   localparam logic [7:0]  LIS_SC_MASTER    = 8'h70;
   localparam logic [7:0]  LIS_SC_SLAVE     = 8'h50;
   localparam logic [7:0]  LIS_SC_RESET     = 8'h00;
   // Divide-by-4 phases and lock qualification.
   localparam logic [1:0]  LIS_PH0          = 2'h0;
   localparam logic [1:0]  LIS_PH90         = 2'h1;
   localparam logic [1:0]  LIS_PH_CHECK     = 2'h2;
   localparam logic [1:0]  LIS_DCO_START    = 2'h2;
   localparam logic [2:0]  LIS_LOCK_LAST    = 3'h3;
   // Controller AXI4-Lite map.
   localparam int unsigned LIS_AXI_AW       = 8;
   localparam logic [7:0]  LIS_H_CMD        = 8'h00;
   localparam logic [7:0]  LIS_H_RESULT     = 8'h04;
   localparam logic [7:0]  LIS_H_SNAP       = 8'h08;
   localparam logic [7:0]  LIS_H_ACK        = 8'h0C;
   localparam logic [7:0]  LIS_H_SYNC       = 8'h10;
   localparam logic [7:0]  LIS_H_IRQ_ST     = 8'h14;
   localparam logic [7:0]  LIS_H_IRQ_MASK   = 8'h18;
   localparam int unsigned LIS_CMD_WE_BIT   = 16;
   localparam int unsigned LIS_HI_CMD_DONE  = 0;
   localparam int unsigned LIS_HI_DEV_IRQ   = 1;
   localparam int unsigned LIS_HI_SNAP_DONE = 2;
   localparam logic [1:0]  LIS_RESP_OKAY    = 2'h0;
endpackage

//--- verif/lis_link_checker.sv
/*
 * Assertions on the device register link.
 * Assumes one clock; the bench instantiates it.
 */
`timescale 1ns/100ps
module lis_link_checker
   import lis_pkg::*;
(
   input wire logic              I_MCLK,
   input wire logic              I_ARST_N,
   input wire logic              req,
   input wire logic              we,
   input wire logic [LIS_AW-1:0] addr,
   input wire logic [LIS_DW-1:0] wdata,
   input wire logic [LIS_DW-1:0] rdata,
   input wire logic              ack,
   input wire logic              irq
);
   logic [7:0] en_sh_ff;
   logic [7:0] sc_sh_ff;
   logic       wr_take;

   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (!I_ARST_N);

   assign wr_take = req && we && !ack;

   // Last enable and sync control written.
   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         en_sh_ff <= 8'h00;
         sc_sh_ff <= 8'h00;
      end else begin
         if (wr_take && addr == LIS_ADDR_IRQ_EN) en_sh_ff <= wdata;
         if (wr_take && addr == LIS_ADDR_SYNC) sc_sh_ff <= wdata;
      end
   end

   sequence s_take;
      req && !ack;
   endsequence
   sequence s_rd(logic [7:0] a);
      req && !we && !ack && addr == a;
   endsequence

   a_ack_on_take: assert property (s_take |=> ack)
      else $error("no ack after take");
   a_ack_one_pulse: assert property (ack |=> !ack)
      else $error("ack too long");
   a_ack_needs_req: assert property (!req |=> !ack)
      else $error("ack without request");
   a_rdata_holds: assert property ($changed(rdata) |-> ack)
      else $error("rdata moved without ack");
   a_unmapped_zero: assert property (s_rd(8'h7F) |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_en_readback: assert property (s_rd(LIS_ADDR_IRQ_EN) |=> rdata[5:0] == en_sh_ff[5:0])
      else $error("enable readback wrong");
   a_sync_readback: assert property (s_rd(LIS_ADDR_SYNC) |=> rdata == sc_sh_ff)
      else $error("sync readback wrong");
   a_status_gated: assert property (s_rd(LIS_ADDR_IRQ_ST) |=> (rdata & ~en_sh_ff) == 8'h00)
      else $error("status without enable");
   a_irq_needs_en: assert property (irq |-> en_sh_ff[5:0] != 6'h00)
      else $error("irq with no enable");
endmodule // lis_link_checker

//--- verif/lock_irq_and_sync_align_bench.sv
/*
 * Bench: controller and master on one link, a bench-driven slave on another,
 * both fed by the master's sync output. Assumes package and link compile first.
 */
`timescale 1ns/100ps
module lock_irq_and_sync_align_bench;
   import lis_pkg::*;
   logic        clk;
   logic        rst_n;
   logic        awv, wv, bre, arv, rre, trk;
   logic        awr, wrd, bv, arr, rv, irq_h, sync_m, dco_m;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rdt;
   logic [3:0]  cond;
   logic [1:0]  br, rr, ph_m, ph_s;
   int          failures;
   int          cmp_count;

   lis_if if_m ();
   lis_if if_s ();

   lis_host i_lis_host (
      .I_MCLK(clk), .I_ARST_N(rst_n), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa),
      .I_WVALID(wv), .O_WREADY(wrd), .I_WDATA(wd), .I_WSTRB(4'hF), .O_BVALID(bv),
      .I_BREADY(bre), .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
      .O_RVALID(rv), .I_RREADY(rre), .O_RDATA(rdt), .O_RRESP(rr), .O_IRQ(irq_h), .bus(if_m));
   lis_device #(.DP_START(2'h0)) i_lis_device_m (
      .I_MCLK(clk), .I_ARST_N(rst_n), .I_DELAY_LOCKED_NOW(cond[2]), .I_DELAY_LOST_NOW(cond[3]),
      .I_RECEIVER_LOCKED_NOW(cond[0]), .I_RECEIVER_LOST_NOW(cond[1]),
      .I_RECEIVER_TRACKING_ACTIVE(trk), .I_SYNC_IN(sync_m), .O_SYNC_OUT(sync_m),
      .O_DATA_CLOCK_OUTPUT(dco_m), .O_DP_PHASE(ph_m), .bus(if_m));
   lis_device #(.DP_START(2'h3)) i_lis_device_s (
      .I_MCLK(clk), .I_ARST_N(rst_n), .I_DELAY_LOCKED_NOW(cond[2]), .I_DELAY_LOST_NOW(cond[3]),
      .I_RECEIVER_LOCKED_NOW(cond[0]), .I_RECEIVER_LOST_NOW(cond[1]),
      .I_RECEIVER_TRACKING_ACTIVE(trk), .I_SYNC_IN(sync_m), .O_SYNC_OUT(),
      .O_DATA_CLOCK_OUTPUT(), .O_DP_PHASE(ph_s), .bus(if_s));
   lis_link_checker i_lis_link_checker (
      .I_MCLK(clk), .I_ARST_N(rst_n), .req(if_m.req), .we(if_m.we), .addr(if_m.addr),
      .wdata(if_m.wdata), .rdata(if_m.rdata), .ack(if_m.ack), .irq(if_m.irq));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic tmo();
      failures++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      summarize();
   endtask

   task automatic check(input logic [31:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      {awa, wd, awv, wv, bre} <= {a, d, 3'h7};
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
         if (bv) break;
      end
      bre <= 1'b0;
      if (n == 100) tmo();
      @(posedge clk);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      {ara, arv, rre} <= {a, 2'h3};
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         if (rv) break;
      end
      d = rdt;
      rre <= 1'b0;
      if (n == 100) tmo();
      @(posedge clk);
   endtask

   // Waits until the controller is idle.
   task automatic idle(output logic [31:0] v);
      int n;
      for (n = 0; n < 50; n++) begin
         axi_rd(LIS_H_RESULT, v);
         if (v[31] === 1'b0) break;
      end
      if (n == 50) tmo();
   endtask

   task automatic dev(input logic w, input logic [7:0] a, d, output logic [7:0] r);
      logic [31:0] v;
      idle(v);
      axi_wr(LIS_H_CMD, {15'h0000, w, a, d});
      idle(v);
      r = v[7:0];
   endtask

   task automatic s_acc(input logic w, input logic [7:0] a, d, output logic [7:0] r);
      int n;
      {if_s.req, if_s.we, if_s.addr, if_s.wdata} <= {1'b1, w, a, d};
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (if_s.ack === 1'b1) break;
      end
      r = if_s.rdata;
      if_s.req <= 1'b0;
      if (n == 20) tmo();
      @(posedge clk);
   endtask

   task automatic t_reset();
      logic [7:0] r;
      logic [7:0] al [4];
      al = '{LIS_ADDR_IRQ_EN, LIS_ADDR_IRQ_ST, LIS_ADDR_SYNC, 8'h7F};
      foreach (al[i]) begin
         dev(1'b0, al[i], 8'h00, r);
         check(r, 8'h00);
      end
      check(if_m.irq, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_events();
      logic [7:0]  r;
      logic [31:0] v;
      trk <= 1'b1;
      dev(1'b1, LIS_ADDR_IRQ_EN, 8'h3F, r);
      for (int i = 0; i < 4; i++) begin
         cond[i] <= 1'b1;
         repeat (6) @(posedge clk);
         dev(1'b0, LIS_ADDR_IRQ_ST, 8'h00, r);
         check(r, 8'((2 << i) - 1));
         check(if_m.irq, 1'b1);
      end
      dev(1'b0, LIS_ADDR_DL_LIVE, 8'h00, r);
      check(r, 8'h03);
      dev(1'b0, LIS_ADDR_RS_LIVE, 8'h00, r);
      check(r & 8'h0B, 8'h0B);
      axi_rd(LIS_H_SNAP, v);
      check({v[23:16], v[7:0]}, 16'h0100);
      dev(1'b1, LIS_ADDR_IRQ_EN, 8'h00, r);
      dev(1'b1, LIS_ADDR_IRQ_EN, 8'h3F, r);
      repeat (4) @(posedge clk);
      dev(1'b0, LIS_ADDR_IRQ_ST, 8'h00, r);
      check(r, 8'h00);
      check(if_m.irq, 1'b0);
      cond <= 4'h0;
      repeat (6) @(posedge clk);
      dev(1'b0, LIS_ADDR_IRQ_ST, 8'h00, r);
      check(r, 8'h00);
      $display("test events done");
   endtask

   task automatic t_gate();
      logic [7:0]  r;
      logic [31:0] v;
      dev(1'b1, LIS_ADDR_IRQ_EN, 8'h04, r);
      cond[0] <= 1'b1;
      repeat (6) @(posedge clk);
      dev(1'b0, LIS_ADDR_IRQ_ST, 8'h00, r);
      check(r, 8'h00);
      check(if_m.irq, 1'b0);
      cond[2] <= 1'b1;
      repeat (6) @(posedge clk);
      dev(1'b0, LIS_ADDR_IRQ_ST, 8'h00, r);
      check(r, 8'h04);
      check(if_m.irq, 1'b1);
      axi_wr(LIS_H_ACK, 32'h0000_0004);
      idle(v);
      check(if_m.irq, 1'b0);
      dev(1'b0, LIS_ADDR_IRQ_EN, 8'h00, r);
      check(r, 8'h04);
      cond <= 4'h0;
      $display("test gating done");
   endtask

   task automatic t_hirq();
      logic [7:0]  r;
      logic [31:0] v;
      axi_rd(LIS_H_IRQ_ST, v);
      axi_wr(LIS_H_IRQ_MASK, 32'h0);
      dev(1'b0, LIS_ADDR_IRQ_EN, 8'h00, r);
      check(irq_h, 1'b0);
      axi_rd(LIS_H_IRQ_ST, v);
      check(v[LIS_HI_CMD_DONE], 1'b1);
      axi_wr(LIS_H_IRQ_MASK, 32'h1);
      dev(1'b0, LIS_ADDR_IRQ_EN, 8'h00, r);
      check(irq_h, 1'b1);
      axi_rd(LIS_H_IRQ_ST, v);
      check(v[LIS_HI_CMD_DONE], 1'b1);
      repeat (2) @(posedge clk);
      check(irq_h, 1'b0);
      $display("test host interrupt done");
   endtask

   task automatic t_sync();
      logic [7:0]  r, ps, pd;
      logic [31:0] v;
      check(2'(ph_s - ph_m), 2'h3);
      axi_wr(LIS_H_SYNC, 32'h1);
      idle(v);
      dev(1'b0, LIS_ADDR_SYNC, 8'h00, r);
      check(r, LIS_SC_MASTER);
      s_acc(1'b1, LIS_ADDR_SYNC, LIS_SC_SLAVE, r);
      repeat (40) @(posedge clk);
      check(ph_s, ph_m);
      s_acc(1'b0, LIS_ADDR_PH_ST, 8'h00, r);
      check(r[5:4], 2'h2);
      dev(1'b0, LIS_ADDR_RS_LIVE, 8'h00, r);
      check(r[4], 1'b1);
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         ps[k] = sync_m;
         pd[k] = dco_m;
      end
      check({ps[7:4], pd[7:4]}, {ps[3:0], pd[3:0]});
      check($countones(ps[3:0]), 2);
      check($countones(pd[3:0]), 2);
      s_acc(1'b1, LIS_ADDR_ROTATE, 8'h01, r);
      repeat (4) @(posedge clk);
      check(ph_s, ph_m);
      s_acc(1'b1, LIS_ADDR_SYNC, 8'h00, r);
      s_acc(1'b1, LIS_ADDR_ROTATE, 8'h01, r);
      repeat (4) @(posedge clk);
      check(ph_s === ph_m, 1'b0);
      $display("test sync done");
   endtask

   initial begin
      rst_n = 1'b0;
      {awv, wv, bre, arv, rre, trk, cond, awa, ara, wd} = '0;
      {if_s.req, if_s.we, if_s.addr, if_s.wdata} = '0;
      failures = 0;
      cmp_count = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_events();
      t_gate();
      t_hirq();
      t_sync();
      summarize();
   end
endmodule // lock_irq_and_sync_align_bench
